/* csp_protect.v */
// Code segment protection: configuration registers on AHB-Lite and flash write filtering.
//
// Design decisions made here: the address map and the AHB-Lite interface to the registers.
`default_nettype none

module csp_protect #(
  parameter AW = 24,
  parameter DW = 24,
  parameter HAS_SECURE = 1
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  input wire wr_req,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  output reg flash_we,
  output reg [AW-1:0] flash_addr,
  output reg [DW-1:0] flash_data,
  output reg wr_refused,
  output reg boot_high_security,
  output reg secure_high_security,
  output reg [15:0] boot_ram_bytes,
  output reg [15:0] secure_ram_bytes
);

`include "csp_map.vh"

  // Protected RAM size for a code; the secure table is used when is_secure is set.
  function [15:0] ram_bytes;
    input [1:0] code;
    input is_secure;
    begin
      case (code)
        `CSP_SIZE_SMALL: ram_bytes = is_secure ? `CSP_SRAM_SMALL : `CSP_BRAM_SMALL;
        `CSP_SIZE_MID: ram_bytes = is_secure ? `CSP_SRAM_MID : `CSP_BRAM_MID;
        `CSP_SIZE_LARGE: ram_bytes = is_secure ? `CSP_SRAM_LARGE : `CSP_BRAM_LARGE;
        default: ram_bytes = 16'h0000;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave: address phase capture.

  reg boot_cfg_q;
  reg [7:0] boot_cfg_r_q;
  reg [7:0] sec_cfg_q;
  reg [7:0] boot_cfg_d;
  reg [7:0] sec_cfg_d;
  reg wr_pend_q;
  reg [7:0] wr_off_q;
  reg [15:0] refuse_cnt_q;
  reg [15:0] refuse_cnt_d;
  reg [AW-1:0] refuse_addr_q;
  reg [31:0] rdata_d;

  wire access = hsel & hready & (htrans == `CSP_HTRANS_NONSEQ);
  wire [7:0] off = haddr[7:0];
  wire wr_data_phase = wr_pend_q;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_off_q <= 8'h00;
    end else begin
      wr_pend_q <= access & hwrite & (hsize == `CSP_HSIZE_WORD);
      wr_off_q <= off;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers; secure fields are absent on the smallest variant.

  always @* begin
    boot_cfg_d = boot_cfg_r_q;
    sec_cfg_d = sec_cfg_q;
    if (wr_data_phase && wr_off_q == `CSP_OFF_BOOT_CFG) begin
      boot_cfg_d = hwdata[7:0] & `CSP_CFG_MASK;
    end else if (wr_data_phase && wr_off_q == `CSP_OFF_SEC_CFG && HAS_SECURE != 0) begin
      sec_cfg_d = hwdata[7:0] & `CSP_CFG_MASK;
    end
    if (HAS_SECURE == 0) begin
      sec_cfg_d = `CSP_CFG_RESET;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boot_cfg_r_q <= `CSP_CFG_RESET;
      sec_cfg_q <= `CSP_CFG_RESET;
      boot_cfg_q <= 1'b0;
    end else begin
      boot_cfg_r_q <= boot_cfg_d;
      sec_cfg_q <= sec_cfg_d;
      boot_cfg_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Segment decode.

  wire boot_def;
  wire boot_high;
  wire [AW-1:0] boot_end;
  wire sec_def_raw;
  wire sec_high;
  wire [AW-1:0] sec_end;

  csp_seg_decode #(
    .AW(AW),
    .END_SMALL(`CSP_BOOT_END_SMALL),
    .END_MID(`CSP_BOOT_END_MID),
    .END_LARGE(`CSP_BOOT_END_LARGE)
  ) u_boot_dec (
    .size_code(boot_cfg_r_q[`CSP_CFG_SIZE_HI:`CSP_CFG_SIZE_LO]),
    .defined(boot_def),
    .high_security(boot_high),
    .end_addr(boot_end)
  );

  csp_seg_decode #(
    .AW(AW),
    .END_SMALL(`CSP_SEC_END_SMALL),
    .END_MID(`CSP_SEC_END_MID),
    .END_LARGE(`CSP_SEC_END_LARGE)
  ) u_sec_dec (
    .size_code(sec_cfg_q[`CSP_CFG_SIZE_HI:`CSP_CFG_SIZE_LO]),
    .defined(sec_def_raw),
    .high_security(sec_high),
    .end_addr(sec_end)
  );

  wire sec_def = sec_def_raw & (HAS_SECURE != 0);
  // The secure segment starts one instruction word past the boot segment's end, or at CSP_BOOT_START when no boot segment is defined.
  wire [AW-1:0] sec_start = boot_def ? boot_end + `CSP_WORD_STEP : `CSP_BOOT_START;
  wire [15:0] bram = ram_bytes(boot_cfg_r_q[`CSP_CFG_RAM_HI:`CSP_CFG_RAM_LO], 1'b0);
  wire [15:0] sram_full = ram_bytes(sec_cfg_q[`CSP_CFG_RAM_HI:`CSP_CFG_RAM_LO], 1'b1);
  // Secure RAM is the table size less the boot RAM, never below zero.
  wire [15:0] sram = (!sec_def_raw && HAS_SECURE == 0) ? 16'h0000 :
                     (sram_full > bram) ? sram_full - bram : 16'h0000;

  ////////////////////////////////////////////////////////////////////////////////
  // Flash write filter, one cycle from request to flash strobe.

  wire in_boot = boot_def && wr_addr >= `CSP_BOOT_START && wr_addr <= boot_end;
  wire in_sec = sec_def && wr_addr >= sec_start && wr_addr <= sec_end;
  wire boot_lock = in_boot & ~boot_cfg_r_q[`CSP_CFG_WP];
  wire sec_lock = in_sec & ~sec_cfg_q[`CSP_CFG_WP];
  wire refuse = wr_req & (boot_lock | sec_lock);

  always @* begin
    refuse_cnt_d = refuse_cnt_q;
    if (wr_data_phase && wr_off_q == `CSP_OFF_REFUSE_CNT) begin
      refuse_cnt_d = 16'h0000;
    end
    // A refusal in the clearing cycle still counts.
    if (refuse && refuse_cnt_d != 16'hffff) begin
      refuse_cnt_d = refuse_cnt_d + 16'h0001;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flash_we <= 1'b0;
      flash_addr <= {AW{1'b0}};
      flash_data <= {DW{1'b0}};
      wr_refused <= 1'b0;
      refuse_cnt_q <= 16'h0000;
      refuse_addr_q <= {AW{1'b0}};
      boot_high_security <= 1'b0;
      secure_high_security <= 1'b0;
      boot_ram_bytes <= 16'h0000;
      secure_ram_bytes <= 16'h0000;
    end else begin
      flash_we <= wr_req & ~refuse;
      if (wr_req && !refuse) begin
        flash_addr <= wr_addr;
        flash_data <= wr_data;
      end
      wr_refused <= refuse;
      refuse_cnt_q <= refuse_cnt_d;
      if (refuse) begin
        refuse_addr_q <= wr_addr;
      end
      boot_high_security <= boot_def & boot_high;
      secure_high_security <= sec_def & sec_high;
      boot_ram_bytes <= bram;
      secure_ram_bytes <= sram;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data, taken from the next values so a just-written word reads back.

  always @* begin
    rdata_d = 32'h0000_0000;
    if (off == `CSP_OFF_BOOT_CFG) begin
      rdata_d[7:0] = boot_cfg_d;
    end else if (off == `CSP_OFF_SEC_CFG) begin
      rdata_d[7:0] = (HAS_SECURE != 0) ? sec_cfg_d : 8'h00;
    end else if (off == `CSP_OFF_STATUS) begin
      rdata_d[3:0] = {sec_def & sec_high, sec_def, boot_def & boot_high, boot_def};
    end else if (off == `CSP_OFF_BOOT_END) begin
      rdata_d[AW-1:0] = boot_end;
    end else if (off == `CSP_OFF_SEC_END) begin
      rdata_d[AW-1:0] = sec_def ? sec_end : {AW{1'b0}};
    end else if (off == `CSP_OFF_RAM_SIZE) begin
      rdata_d = {sram, bram};
    end else if (off == `CSP_OFF_REFUSE_CNT) begin
      rdata_d[15:0] = refuse_cnt_d;
    end else if (off == `CSP_OFF_REFUSE_ADDR) begin
      rdata_d[AW-1:0] = refuse_addr_q;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= boot_cfg_q;
      hresp <= 1'b0;
      if (access && !hwrite) begin
        hrdata <= rdata_d;
      end
    end
  end

endmodule // csp_protect

`default_nettype wire

/* csp_map.vh */
// Address map, field layout and constants of the code segment protection block.
//
// What this block does
// - A program-flash write into the boot segment is refused while its write-protect field is 0 and let through while it is 1.
// - A boot size code whose two low bits are 11 defines no boot segment, whatever the top bit.
// - Boot size code 110 gives a standard-security 1K-word boot segment ending at 0x0007FE, and 010 gives the same span with high security.
// - Boot size code 101 gives a standard-security 4K-word boot segment ending at 0x001FFE, and 001 gives the same span with high security.
// - Boot size code 100 gives a standard-security 8K-word boot segment ending at 0x003FFE, and 000 gives the same span with high security.
// - The boot RAM size code gives no protected RAM for 11, 128 bytes for 10, 256 bytes for 01 and 1024 bytes for 00.
// - A program-flash write into the secure segment is refused while its write-protect field is 0 and let through while it is 1.
// - A secure size code whose two low bits are 11 defines no secure segment.
// - Secure size code 110 gives a standard-security segment from the end of the boot segment to 0x001FFE, and 010 the same with high security.
// - Secure size code 101 gives a standard-security segment from the end of the boot segment to 0x003FFE, and 001 the same with high security.
// - Secure size code 100 gives a standard-security segment from the end of the boot segment to 0x007FFE, and 000 the same with high security.
// - The secure RAM size code gives none for 11 and 256, 2048 or 4096 bytes for 10, 01 and 00, each less the boot RAM size.
// - The smallest-memory variant has no secure segment and no secure configuration fields.
`ifndef CSP_MAP_VH
`define CSP_MAP_VH

`define CSP_OFF_BOOT_CFG 8'h00
`define CSP_OFF_SEC_CFG 8'h04
`define CSP_OFF_STATUS 8'h08
`define CSP_OFF_BOOT_END 8'h0c
`define CSP_OFF_SEC_END 8'h10
`define CSP_OFF_RAM_SIZE 8'h14
`define CSP_OFF_REFUSE_CNT 8'h18
`define CSP_OFF_REFUSE_ADDR 8'h1c

`define CSP_CFG_WP 0
`define CSP_CFG_SIZE_LO 1
`define CSP_CFG_SIZE_HI 3
`define CSP_CFG_RAM_LO 4
`define CSP_CFG_RAM_HI 5
`define CSP_CFG_RESET 8'h3f
`define CSP_CFG_MASK 8'h3f

`define CSP_SIZE_NONE 2'b11
`define CSP_SIZE_SMALL 2'b10
`define CSP_SIZE_MID 2'b01
`define CSP_SIZE_LARGE 2'b00

`define CSP_BOOT_END_SMALL 24'h00_07fe
`define CSP_BOOT_END_MID 24'h00_1ffe
`define CSP_BOOT_END_LARGE 24'h00_3ffe
`define CSP_SEC_END_SMALL 24'h00_1ffe
`define CSP_SEC_END_MID 24'h00_3ffe
`define CSP_SEC_END_LARGE 24'h00_7ffe
`define CSP_BOOT_START 24'h00_0200
`define CSP_WORD_STEP 24'h00_0002

`define CSP_BRAM_SMALL 16'h0080
`define CSP_BRAM_MID 16'h0100
`define CSP_BRAM_LARGE 16'h0400
`define CSP_SRAM_SMALL 16'h0100
`define CSP_SRAM_MID 16'h0800
`define CSP_SRAM_LARGE 16'h1000

`define CSP_HTRANS_NONSEQ 2'b10
`define CSP_HSIZE_WORD 3'b010

`endif

/* csp_seg_decode.v */
// Decoder from a segment size code to segment presence, security level and end address.
`default_nettype none

module csp_seg_decode #(
  parameter AW = 24,
  parameter [AW-1:0] END_SMALL = {AW{1'b0}},
  parameter [AW-1:0] END_MID = {AW{1'b0}},
  parameter [AW-1:0] END_LARGE = {AW{1'b0}}
) (
  input wire [2:0] size_code,
  output reg defined,
  output reg high_security,
  output reg [AW-1:0] end_addr
);

`include "csp_map.vh"

  // The top bit picks standard (1) or high (0) security; the low bits pick the span.
  always @* begin
    defined = 1'b1;
    high_security = ~size_code[2];
    end_addr = END_LARGE;
    case (size_code[1:0])
      `CSP_SIZE_NONE: begin
        defined = 1'b0;
        high_security = 1'b0;
        end_addr = {AW{1'b0}};
      end
      `CSP_SIZE_SMALL: begin
        end_addr = END_SMALL;
      end
      `CSP_SIZE_MID: begin
        end_addr = END_MID;
      end
      default: begin
        end_addr = END_LARGE;
      end
    endcase
  end

endmodule // csp_seg_decode

`default_nettype wire

/* csp_protect_sva.sv */
// Port-level assertions for the code segment protection block.
`default_nettype none
module csp_protect_sva #(
  parameter AW = 24,
  parameter DW = 24
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic wr_req,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic flash_we,
  input wire logic [AW-1:0] flash_addr,
  input wire logic [DW-1:0] flash_data,
  input wire logic wr_refused,
  input wire logic [15:0] boot_ram_bytes,
  input wire logic [15:0] secure_ram_bytes
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_one_outcome: assert property (wr_req |=> flash_we != wr_refused)
    else $error("request without one outcome");
  chk_idle_quiet: assert property (!wr_req |=> !flash_we && !wr_refused)
    else $error("outcome without request");
  chk_pass_addr: assert property (flash_we |-> flash_addr == $past(wr_addr))
    else $error("passed address wrong");
  chk_pass_data: assert property (flash_we |-> flash_data == $past(wr_data))
    else $error("passed data wrong");
  chk_refuse_span: assert property (wr_refused |->
    $past(wr_addr) inside {[24'h00_0200:24'h00_7ffe]})
    else $error("refusal outside segments");
  chk_vector_open: assert property (wr_req && wr_addr < 24'h00_0200 |=> flash_we)
    else $error("vector write refused");
  chk_top_open: assert property (wr_req && wr_addr > 24'h00_7ffe |=> flash_we)
    else $error("write above segments refused");
  chk_bram_code: assert property (
    boot_ram_bytes inside {16'h0000, 16'h0080, 16'h0100, 16'h0400})
    else $error("boot RAM size illegal");
  chk_sram_limit: assert property (secure_ram_bytes <= 16'h1000)
    else $error("secure RAM size too large");
endmodule // csp_protect_sva

bind csp_protect csp_protect_sva #(.AW(AW), .DW(DW)) u_csp_protect_sva (
  .hclk(hclk), .hresetn(hresetn), .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data),
  .flash_we(flash_we), .flash_addr(flash_addr), .flash_data(flash_data),
  .wr_refused(wr_refused), .boot_ram_bytes(boot_ram_bytes),
  .secure_ram_bytes(secure_ram_bytes));
`default_nettype wire

/* tb_csp_protect.sv */
// Self-checking bench for the code segment protection block.
`include "csp_map.vh"
`default_nettype none
module tb_csp_protect;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, wr_req, flash_we, wr_refused;
  logic boot_high_security, secure_high_security;
  logic [1:0] htrans, c;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, cfg;
  logic [23:0] wr_addr, wr_data, flash_addr, flash_data, e;
  logic [15:0] boot_ram_bytes, secure_ram_bytes, r;
  int failures, n_tests;

  csp_protect #(.AW(24), .DW(24), .HAS_SECURE(1)) u_csp_protect (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .wr_req(wr_req),
    .wr_addr(wr_addr), .wr_data(wr_data), .flash_we(flash_we), .flash_addr(flash_addr),
    .flash_data(flash_data), .wr_refused(wr_refused),
    .boot_high_security(boot_high_security), .secure_high_security(secure_high_security),
    .boot_ram_bytes(boot_ram_bytes), .secure_ram_bytes(secure_ram_bytes));

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= `CSP_HTRANS_NONSEQ;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    check(rd, x);
    check({31'h0, hresp}, 32'h0000_0000);
  endtask

  // Sends one flash write and checks which way it went one edge later.
  task automatic flash(input logic [23:0] a, input logic pass);
    @(posedge hclk);
    wr_req <= 1'b1;
    wr_addr <= a;
    wr_data <= ~a;
    @(posedge hclk);
    wr_req <= 1'b0;
    #1;
    check({flash_we, wr_refused}, {pass, !pass});
    if (pass) check({8'h00, flash_addr}, {8'h00, a});
    if (pass) check({8'h00, flash_data}, {8'h00, ~a});
  endtask

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100us;
    failures++;
    wrap_up();
  end

  initial begin
    {hresetn, hsel, hwrite, wr_req, htrans, haddr, hwdata, wr_addr, wr_data} = '0;
    hsize = `CSP_HSIZE_WORD;
    failures = 0;
    n_tests = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(`CSP_OFF_BOOT_CFG, 32'h0000_003f);
    rd_chk(`CSP_OFF_SEC_CFG, 32'h0000_003f);
    bus(1'b1, 8'h20, 32'hffff_ffff);
    rd_chk(8'h20, 32'h0000_0000);
    flash(24'h00_0200, 1'b1);
    $display("reset and map test done");
    for (int i = 0; i < 8; i++) begin
      c = i[1:0];
      e = c == 2'b11 ? 24'h00_0000 : c == 2'b10 ? 24'h00_07fe : c == 2'b01 ? 24'h00_1ffe
        : 24'h00_3ffe;
      r = c == 2'b00 ? 16'h0000 : c == 2'b01 ? 16'h0080 : c == 2'b10 ? 16'h0100 : 16'h0400;
      cfg = {~c, i[2:0], 1'b0};
      bus(1'b1, `CSP_OFF_BOOT_CFG, cfg);
      rd_chk(`CSP_OFF_BOOT_CFG, cfg);
      rd_chk(`CSP_OFF_BOOT_END, {8'h00, e});
      rd_chk(`CSP_OFF_STATUS, {30'h0, !i[2] && c != 2'b11, c != 2'b11});
      check({31'h0, boot_high_security}, {31'h0, !i[2] && c != 2'b11});
      check({16'h0000, boot_ram_bytes}, {16'h0000, r});
      flash(24'h00_0200, c == 2'b11);
      flash(e, e == 24'h00_0000);
      flash(e + 24'h00_0002, 1'b1);
    end
    bus(1'b1, `CSP_OFF_BOOT_CFG, 32'h0000_0029);
    flash(24'h00_3ffe, 1'b1);
    $display("boot segment test done");
    bus(1'b1, `CSP_OFF_BOOT_CFG, 32'h0000_002c);
    for (int i = 0; i < 8; i++) begin
      c = i[1:0];
      e = c == 2'b11 ? 24'h00_0000 : c == 2'b10 ? 24'h00_1ffe : c == 2'b01 ? 24'h00_3ffe
        : 24'h00_7ffe;
      r = c == 2'b00 ? 16'h0000 : c == 2'b01 ? 16'h0080 : c == 2'b10 ? 16'h0780 : 16'h0f80;
      bus(1'b1, `CSP_OFF_SEC_CFG, {~c, i[2:0], 1'b0});
      rd_chk(`CSP_OFF_SEC_END, {8'h00, e});
      rd_chk(`CSP_OFF_STATUS, {28'h0, !i[2] && c != 2'b11, c != 2'b11, 2'b01});
      check({31'h0, secure_high_security}, {31'h0, !i[2] && c != 2'b11});
      rd_chk(`CSP_OFF_RAM_SIZE, {r, 16'h0080});
      flash(24'h00_0800, c == 2'b11);
      flash(e, e == 24'h00_0000);
      flash(e + 24'h00_0002, 1'b1);
    end
    bus(1'b1, `CSP_OFF_SEC_CFG, 32'h0000_0009);
    flash(24'h00_0800, 1'b1);
    flash(24'h00_07fe, 1'b0);
    rd_chk(`CSP_OFF_REFUSE_CNT, 32'h0000_0019);
    rd_chk(`CSP_OFF_REFUSE_ADDR, 32'h0000_07fe);
    bus(1'b1, `CSP_OFF_REFUSE_CNT, 32'h0000_0000);
    rd_chk(`CSP_OFF_REFUSE_CNT, 32'h0000_0000);
    $display("secure segment test done");
    wrap_up();
  end
endmodule // tb_csp_protect
`default_nettype wire
